// ---- logic/ralc_pkg.sv ----
/*
 * Constants shared by the recording level control loop and its level
 * detector: register offsets, field positions, reset values and widths.
 * Assumes a 32-bit AHB-Lite register port and a 24-bit sample stream.
 */
// Contract
// - Each of the four channels has its own loop enable.
// - Measure the post-ADC signal level and steer gain toward it.
// - Above the maximum threshold, keep lowering gain until below it.
// - Below the minimum threshold, keep raising gain until above it.
// - Between the thresholds, leave the gain unchanged.
// - Two modes: digital-only, and hybrid chosen by the sync-mode bit.
// - Digital-only mode changes digital gain only, ignoring channel gain registers; the code drives analog gain from chAmp.
// - Loop digital gain stays between maximum attenuation and maximum gain.
// - Hybrid mode controls analog amplifier gain plus digital gain together.
// - Hybrid mode ignores and never writes amplifier and digital gain registers.
// - Loop analog gain stays between the analog minimum and maximum.
// - Attack lowers gain at attack rate; decay raises it at release rate.
// - After an attack, hold the gain for the hold time before decay.
// - Anti-clip near full scale forces fast attack; threshold is programmable.
// - Below the noise threshold the gain is never raised.
// - Software sets calibration bit before hybrid; hardware clears it when done.
package ralc_pkg;
	localparam int NCH    = 4;
	localparam int LVL_W  = 5;
	localparam int DIG_W  = 7;
	localparam int ANA_W  = 4;
	localparam int RATE_W = 4;
	localparam int HOLD_W = 8;
	localparam int ACS_W  = 3;
	localparam int SMP_W  = 24;
	localparam int CAL_W  = 6;

	localparam logic [7:0] OFF_CTRL_A = 8'h00;
	localparam logic [7:0] OFF_CTRL_B = 8'h04;
	localparam logic [7:0] OFF_CTRL_C = 8'h08;
	localparam logic [7:0] OFF_THR    = 8'h0C;
	localparam logic [7:0] OFF_LIM    = 8'h10;
	localparam logic [7:0] OFF_CHG    = 8'h14;
	localparam logic [7:0] OFF_STAT   = 8'h24;
	localparam logic [7:0] CH_SPAN    = 8'h0C;
	localparam int         WORD_SH    = 2;

	localparam int CA_EN    = 0;
	localparam int CA_SYNC  = 4;
	localparam int CA_ACLIP = 5;
	localparam int CA_CALIB = 6;
	localparam int CB_ATK   = 0;
	localparam int CB_REL   = 4;
	localparam int CC_HOLD  = 0;
	localparam int CC_ACS   = 8;
	localparam int TH_MIN   = 0;
	localparam int TH_MAX   = 8;
	localparam int TH_NOISE = 16;
	localparam int LM_DMIN  = 0;
	localparam int LM_DMAX  = 8;
	localparam int LM_AMIN  = 16;
	localparam int LM_AMAX  = 24;
	localparam int CG_DIG   = 0;
	localparam int CG_AMP   = 8;
	localparam int ST_DIG   = 0;
	localparam int ST_ANA   = 8;
	localparam int ST_PH    = 16;
	localparam int HT_ACT   = 1;

	localparam logic [DIG_W-1:0]  RST_DIG   = 7'h40;
	localparam logic [ANA_W-1:0]  RST_AMP   = 4'h6;
	localparam logic [DIG_W-1:0]  RST_DMIN  = 7'h00;
	localparam logic [DIG_W-1:0]  RST_DMAX  = 7'h7F;
	localparam logic [ANA_W-1:0]  RST_AMIN  = 4'h0;
	localparam logic [ANA_W-1:0]  RST_AMAX  = 4'hF;
	localparam logic [LVL_W-1:0]  RST_THMIN = 5'h0E;
	localparam logic [LVL_W-1:0]  RST_THMAX = 5'h12;
	localparam logic [LVL_W-1:0]  RST_NOISE = 5'h04;
	localparam logic [RATE_W-1:0] RST_ATK   = 4'h0;
	localparam logic [RATE_W-1:0] RST_REL   = 4'h8;
	localparam logic [HOLD_W-1:0] RST_HOLD  = 8'h10;
	localparam logic [ACS_W-1:0]  RST_ACS   = 3'h2;
	localparam logic [LVL_W-1:0]  LVL_TOP   = 5'h16;
	localparam logic [CAL_W-1:0]  CAL_LAST  = 6'h3F;
	localparam int                CAL_CYCLES = 64;

	typedef enum logic [1:0] {
		PH_STEADY,
		PH_ATTACK,
		PH_HOLD,
		PH_DECAY
	} ralc_phase_t;
endpackage : ralc_pkg

// ---- logic/ralc_lvl_if.sv ----
/*
 * Carrier for measured levels from the detector to the gain loop.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface ralc_lvl_if;
	logic       lvlValid;
	logic [1:0] lvlChan;
	logic [4:0] lvlCode;
	modport src (output lvlValid, lvlChan, lvlCode);
	modport snk (input lvlValid, lvlChan, lvlCode);
endinterface : ralc_lvl_if

// ---- logic/ralc_level_det.sv ----
/*
 * Level detector: turns each signed sample into a log2 magnitude code.
 * Assumes samples arrive from the ADC filter path on the same clock.
 */
`timescale 1ns/100ps
module ralc_level_det
	import ralc_pkg::*;
(
	input  wire logic             clk,      // System clock.
	input  wire logic             sys_rst,  // Asynchronous reset.
	input  wire logic             ce,       // Clock enable.
	input  wire logic             smpValid, // Sample strobe.
	input  wire logic [1:0]       smpChan,  // Sample channel.
	input  wire logic [SMP_W-1:0] smpData,  // Signed sample.
	ralc_lvl_if.src               lv        // Measured level out.
);
	typedef struct packed {
		logic             valid;
		logic [1:0]       chan;
		logic [LVL_W-1:0] code;
	} ralc_det_t;

	ralc_det_t        st_ff;
	ralc_det_t        nxt_st;
	logic [SMP_W-1:0] mag;

	// One's complement magnitude avoids the overflow of negating the most
	// negative sample; the one-LSB error is far below one 6 dB code step.
	always_comb begin
		nxt_st       = st_ff;
		mag          = smpData[SMP_W-1] ? ~smpData : smpData;
		nxt_st.valid = smpValid;
		if (smpValid) begin
			nxt_st.chan = smpChan;
			nxt_st.code = '0;
			for (int i = 0; i < SMP_W; i++) begin
				if (mag[i]) begin
					nxt_st.code = LVL_W'(i);
				end
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign lv.lvlValid = st_ff.valid;
	assign lv.lvlChan  = st_ff.chan;
	assign lv.lvlCode  = st_ff.code;
endmodule : ralc_level_det

// ---- logic/ralc_core.sv ----
/*
 * Recording level control loop for four channels with AHB-Lite registers.
 * Assumes one AHB-Lite master and samples on the same clock as the bus.
 */
`timescale 1ns/100ps
module ralc_core
	import ralc_pkg::*;
(
	input  wire logic                 clk,       // System clock, 40 MHz.
	input  wire logic                 sys_rst,   // Asynchronous reset.
	input  wire logic                 ce,        // Clock enable.
	input  wire logic                 hsel,      // Slave select.
	input  wire logic [31:0]          haddr,     // Byte address.
	input  wire logic [1:0]           htrans,    // Transfer type.
	input  wire logic                 hwrite,    // Write when high.
	input  wire logic [2:0]           hsize,     // Word only.
	input  wire logic [31:0]          hwdata,    // Write data.
	input  wire logic                 hready,    // Bus ready.
	output logic                      hreadyout, // Slave ready.
	output logic [31:0]               hrdata,    // Read data.
	output logic                      hresp,     // Always OKAY.
	input  wire logic                 smpValid,  // Sample strobe.
	input  wire logic [1:0]           smpChan,   // Sample channel.
	input  wire logic [SMP_W-1:0]     smpData,   // Signed sample.
	output logic [NCH*DIG_W-1:0]      digGain,   // Digital gain per chan.
	output logic [NCH*ANA_W-1:0]      anaGain,   // Mic amp gain per chan.
	output logic                      calibRun   // Offset calibration.
);
	typedef struct packed {
		logic [NCH-1:0]              en;
		logic                        sync;
		logic                        aclip;
		logic                        calib;
		logic [CAL_W-1:0]            calCnt;
		logic [RATE_W-1:0]           atk;
		logic [RATE_W-1:0]           rel;
		logic [HOLD_W-1:0]           hold;
		logic [ACS_W-1:0]            acStep;
		logic [LVL_W-1:0]            thrMin;
		logic [LVL_W-1:0]            thrMax;
		logic [LVL_W-1:0]            thrNoise;
		logic [DIG_W-1:0]            dMin;
		logic [DIG_W-1:0]            dMax;
		logic [ANA_W-1:0]            aMin;
		logic [ANA_W-1:0]            aMax;
		logic [NCH-1:0][DIG_W-1:0]   chDig;
		logic [NCH-1:0][ANA_W-1:0]   chAmp;
		logic [NCH-1:0][DIG_W-1:0]   loopDig;
		logic [NCH-1:0][ANA_W-1:0]   loopAna;
		ralc_phase_t [NCH-1:0]       phase;
		logic [NCH-1:0][HOLD_W-1:0]  holdCnt;
		logic [NCH-1:0][RATE_W-1:0]  rateCnt;
		logic [NCH-1:0][DIG_W-1:0]   digOut;
		logic [NCH-1:0][ANA_W-1:0]   anaOut;
		logic                        wrPend;
		logic                        rdPend;
		logic [7:0]                  busAddr;
		logic                        ready;
		logic                        resp;
		logic [31:0]                 rdata;
	} ralc_state_t;

	localparam ralc_state_t ST_RST = '{
		atk: RST_ATK, rel: RST_REL, hold: RST_HOLD, acStep: RST_ACS,
		thrMin: RST_THMIN, thrMax: RST_THMAX, thrNoise: RST_NOISE,
		dMin: RST_DMIN, dMax: RST_DMAX, aMin: RST_AMIN, aMax: RST_AMAX,
		chDig: {NCH{RST_DIG}}, chAmp: {NCH{RST_AMP}},
		loopDig: {NCH{RST_DIG}}, loopAna: {NCH{RST_AMP}},
		digOut: {NCH{RST_DIG}}, anaOut: {NCH{RST_AMP}},
		phase: '{NCH{PH_STEADY}}, ready: 1'b1, default: '0};

	ralc_state_t      st_ff;
	ralc_state_t      nxt_st;
	ralc_lvl_if       lv ();
	logic [1:0]       c;
	logic             over;
	logic             under;
	logic             gated;
	logic             clipNear;
	logic [31:0]      rd;

	ralc_level_det u_det (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.ce       (ce),
		.smpValid (smpValid),
		.smpChan  (smpChan),
		.smpData  (smpData),
		.lv       (lv)
	);

	function automatic logic [DIG_W-1:0] limG(logic [DIG_W-1:0] v,
		logic [DIG_W-1:0] lo, logic [DIG_W-1:0] hi);
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction : limG

	function automatic logic chHit(logic [7:0] a, logic [7:0] base);
		return (a >= base) && (a <= base + CH_SPAN) && (a[1:0] == 2'h0);
	endfunction : chHit

	function automatic logic [1:0] chIdx(logic [7:0] a, logic [7:0] base);
		return 2'((a - base) >> WORD_SH);
	endfunction : chIdx

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.ready  = 1'b1;
		nxt_st.resp   = 1'b0;
		nxt_st.wrPend = 1'b0;
		c        = lv.lvlChan;
		over     = lv.lvlCode > st_ff.thrMax;
		under    = lv.lvlCode < st_ff.thrMin;
		gated    = lv.lvlCode < st_ff.thrNoise;
		clipNear = st_ff.aclip && (lv.lvlCode >= LVL_TOP - st_ff.acStep);
		rd       = '0;

		if (st_ff.calib) begin
			if (st_ff.calCnt == CAL_LAST) begin
				nxt_st.calib = 1'b0;
			end else begin
				nxt_st.calCnt = st_ff.calCnt + 1'b1;
			end
		end

		// Gains are frozen while the offset calibration runs so that the
		// measured offset is not disturbed by a moving amplifier gain.
		if (lv.lvlValid && st_ff.en[c] && !st_ff.calib) begin
			if (over) begin
				nxt_st.phase[c]   = PH_ATTACK;
				nxt_st.holdCnt[c] = st_ff.hold;
				if (clipNear || st_ff.rateCnt[c] == '0) begin
					nxt_st.rateCnt[c] = st_ff.atk;
					if (st_ff.sync && st_ff.loopAna[c] > st_ff.aMin) begin
						nxt_st.loopAna[c] = st_ff.loopAna[c] - 1'b1;
					end else if (st_ff.loopDig[c] > st_ff.dMin) begin
						nxt_st.loopDig[c] = st_ff.loopDig[c] - 1'b1;
					end
				end else begin
					nxt_st.rateCnt[c] = st_ff.rateCnt[c] - 1'b1;
				end
			end else if (under && !gated) begin
				if (st_ff.holdCnt[c] != '0) begin
					nxt_st.phase[c]   = PH_HOLD;
					nxt_st.holdCnt[c] = st_ff.holdCnt[c] - 1'b1;
				end else if (st_ff.rateCnt[c] == '0) begin
					nxt_st.phase[c]   = PH_DECAY;
					nxt_st.rateCnt[c] = st_ff.rel;
					if (st_ff.sync && st_ff.loopAna[c] < st_ff.aMax) begin
						nxt_st.loopAna[c] = st_ff.loopAna[c] + 1'b1;
					end else if (st_ff.loopDig[c] < st_ff.dMax) begin
						nxt_st.loopDig[c] = st_ff.loopDig[c] + 1'b1;
					end
				end else begin
					nxt_st.phase[c]   = PH_DECAY;
					nxt_st.rateCnt[c] = st_ff.rateCnt[c] - 1'b1;
				end
			end else begin
				// In the window or under the noise gate: gain stays put.
				nxt_st.phase[c]   = PH_STEADY;
				nxt_st.rateCnt[c] = '0;
				if (st_ff.holdCnt[c] != '0) begin
					nxt_st.holdCnt[c] = st_ff.holdCnt[c] - 1'b1;
				end
			end
		end

		for (int i = 0; i < NCH; i++) begin
			if (!st_ff.en[i]) begin
				// Seeding from the programmed gains avoids a jump on enable.
				nxt_st.loopDig[i] = st_ff.chDig[i];
				nxt_st.loopAna[i] = st_ff.chAmp[i];
				nxt_st.phase[i]   = PH_STEADY;
				nxt_st.holdCnt[i] = '0;
				nxt_st.rateCnt[i] = '0;
			end
			nxt_st.digOut[i] = st_ff.en[i] ?
				limG(st_ff.loopDig[i], st_ff.dMin, st_ff.dMax) :
				st_ff.chDig[i];
			nxt_st.anaOut[i] = (st_ff.en[i] && st_ff.sync) ?
				ANA_W'(limG(DIG_W'(st_ff.loopAna[i]), DIG_W'(st_ff.aMin),
				DIG_W'(st_ff.aMax))) :
				st_ff.chAmp[i];
		end

		if (st_ff.wrPend) begin
			unique case (st_ff.busAddr)
				OFF_CTRL_A: begin
					nxt_st.en    = hwdata[CA_EN +: NCH];
					nxt_st.sync  = hwdata[CA_SYNC];
					nxt_st.aclip = hwdata[CA_ACLIP];
					if (hwdata[CA_CALIB]) begin
						nxt_st.calib  = 1'b1;
						nxt_st.calCnt = '0;
					end
				end
				OFF_CTRL_B: begin
					nxt_st.atk = hwdata[CB_ATK +: RATE_W];
					nxt_st.rel = hwdata[CB_REL +: RATE_W];
				end
				OFF_CTRL_C: begin
					nxt_st.hold   = hwdata[CC_HOLD +: HOLD_W];
					nxt_st.acStep = hwdata[CC_ACS +: ACS_W];
				end
				OFF_THR: begin
					nxt_st.thrMin   = hwdata[TH_MIN +: LVL_W];
					nxt_st.thrMax   = hwdata[TH_MAX +: LVL_W];
					nxt_st.thrNoise = hwdata[TH_NOISE +: LVL_W];
				end
				OFF_LIM: begin
					nxt_st.dMin = hwdata[LM_DMIN +: DIG_W];
					nxt_st.dMax = hwdata[LM_DMAX +: DIG_W];
					nxt_st.aMin = hwdata[LM_AMIN +: ANA_W];
					nxt_st.aMax = hwdata[LM_AMAX +: ANA_W];
				end
				default: begin
					if (chHit(st_ff.busAddr, OFF_CHG)) begin
						nxt_st.chDig[chIdx(st_ff.busAddr, OFF_CHG)] =
							hwdata[CG_DIG +: DIG_W];
						nxt_st.chAmp[chIdx(st_ff.busAddr, OFF_CHG)] =
							hwdata[CG_AMP +: ANA_W];
					end
				end
			endcase
		end

		// Reads take one wait state so a read right after a write sees it.
		if (st_ff.rdPend) begin
			unique case (st_ff.busAddr)
				OFF_CTRL_A: begin
					rd[CA_EN +: NCH] = st_ff.en;
					rd[CA_SYNC]      = st_ff.sync;
					rd[CA_ACLIP]     = st_ff.aclip;
					rd[CA_CALIB]     = st_ff.calib;
				end
				OFF_CTRL_B: begin
					rd[CB_ATK +: RATE_W] = st_ff.atk;
					rd[CB_REL +: RATE_W] = st_ff.rel;
				end
				OFF_CTRL_C: begin
					rd[CC_HOLD +: HOLD_W] = st_ff.hold;
					rd[CC_ACS +: ACS_W]   = st_ff.acStep;
				end
				OFF_THR: begin
					rd[TH_MIN +: LVL_W]   = st_ff.thrMin;
					rd[TH_MAX +: LVL_W]   = st_ff.thrMax;
					rd[TH_NOISE +: LVL_W] = st_ff.thrNoise;
				end
				OFF_LIM: begin
					rd[LM_DMIN +: DIG_W] = st_ff.dMin;
					rd[LM_DMAX +: DIG_W] = st_ff.dMax;
					rd[LM_AMIN +: ANA_W] = st_ff.aMin;
					rd[LM_AMAX +: ANA_W] = st_ff.aMax;
				end
				default: begin
					if (chHit(st_ff.busAddr, OFF_CHG)) begin
						rd[CG_DIG +: DIG_W] =
							st_ff.chDig[chIdx(st_ff.busAddr, OFF_CHG)];
						rd[CG_AMP +: ANA_W] =
							st_ff.chAmp[chIdx(st_ff.busAddr, OFF_CHG)];
					end else if (chHit(st_ff.busAddr, OFF_STAT)) begin
						rd[ST_DIG +: DIG_W] =
							st_ff.digOut[chIdx(st_ff.busAddr, OFF_STAT)];
						rd[ST_ANA +: ANA_W] =
							st_ff.anaOut[chIdx(st_ff.busAddr, OFF_STAT)];
						rd[ST_PH +: 2] =
							st_ff.phase[chIdx(st_ff.busAddr, OFF_STAT)];
					end
				end
			endcase
			nxt_st.rdata  = rd;
			nxt_st.rdPend = 1'b0;
		end

		if (hsel && htrans[HT_ACT] && hready) begin
			nxt_st.busAddr = haddr[7:0];
			if (hwrite) begin
				nxt_st.wrPend = 1'b1;
			end else begin
				nxt_st.rdPend = 1'b1;
				nxt_st.ready  = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= ST_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = st_ff.ready;
	assign hresp     = st_ff.resp;
	assign hrdata    = st_ff.rdata;
	assign digGain   = st_ff.digOut;
	assign anaGain   = st_ff.anaOut;
	assign calibRun  = st_ff.calib;

	localparam int CAL_BND = CAL_CYCLES + 2;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst || !ce);

	sequence s_ev0;
		lv.lvlValid && lv.lvlChan == 2'h0 && st_ff.en[0] && !st_ff.calib;
	endsequence
	sequence s_over0;
		s_ev0 ##0 lv.lvlCode > st_ff.thrMax;
	endsequence

	property p_dig_range;
		st_ff.en[0] && st_ff.dMin <= st_ff.dMax |=>
			st_ff.digOut[0] >= $past(st_ff.dMin) &&
			st_ff.digOut[0] <= $past(st_ff.dMax);
	endproperty
	a_dig_range: assert property (p_dig_range)
		else $error("digital gain left its limits");

	property p_ana_range;
		st_ff.en[0] && st_ff.sync && st_ff.aMin <= st_ff.aMax |=>
			st_ff.anaOut[0] >= $past(st_ff.aMin) &&
			st_ff.anaOut[0] <= $past(st_ff.aMax);
	endproperty
	a_ana_range: assert property (p_ana_range)
		else $error("analog gain left its limits");

	property p_bypass;
		!st_ff.en[0] |=> st_ff.digOut[0] == $past(st_ff.chDig[0]) &&
			st_ff.anaOut[0] == $past(st_ff.chAmp[0]);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("disabled channel not using programmed gains");

	property p_dmode;
		st_ff.en[0] && !st_ff.sync |=>
			st_ff.anaOut[0] == $past(st_ff.chAmp[0]);
	endproperty
	a_dmode: assert property (p_dmode)
		else $error("digital-only mode moved the analog gain");

	property p_window;
		s_ev0 ##0 (lv.lvlCode >= st_ff.thrMin &&
			lv.lvlCode <= st_ff.thrMax) |=>
			$stable(st_ff.loopDig[0]) && $stable(st_ff.loopAna[0]);
	endproperty
	a_window: assert property (p_window)
		else $error("gain changed inside the level window");

	property p_attack;
		s_over0 ##0 (!st_ff.sync && st_ff.rateCnt[0] == '0 &&
			st_ff.loopDig[0] > st_ff.dMin) |=>
			st_ff.loopDig[0] == $past(st_ff.loopDig[0]) - 1;
	endproperty
	a_attack: assert property (p_attack)
		else $error("gain not lowered above maximum");

	property p_anticlip;
		s_over0 ##0 (st_ff.aclip && !st_ff.sync &&
			lv.lvlCode >= LVL_TOP - st_ff.acStep &&
			st_ff.loopDig[0] > st_ff.dMin) |=>
			st_ff.loopDig[0] < $past(st_ff.loopDig[0]);
	endproperty
	a_anticlip: assert property (p_anticlip)
		else $error("anti-clip did not force a gain step");

	property p_hold_load;
		s_over0 |=> st_ff.holdCnt[0] == $past(st_ff.hold) &&
			st_ff.phase[0] == PH_ATTACK;
	endproperty
	a_hold_load: assert property (p_hold_load)
		else $error("hold time not loaded on attack");

	property p_hold_keep;
		s_ev0 ##0 (lv.lvlCode < st_ff.thrMin &&
			lv.lvlCode >= st_ff.thrNoise && st_ff.holdCnt[0] != '0) |=>
			$stable(st_ff.loopDig[0]) && $stable(st_ff.loopAna[0]);
	endproperty
	a_hold_keep: assert property (p_hold_keep)
		else $error("gain decayed during hold");

	property p_noise;
		s_ev0 ##0 lv.lvlCode < st_ff.thrNoise ##0
			lv.lvlCode <= st_ff.thrMax |=>
			st_ff.loopDig[0] <= $past(st_ff.loopDig[0]);
	endproperty
	a_noise: assert property (p_noise)
		else $error("gain raised under the noise gate");

	property p_calib;
		$rose(st_ff.calib) |-> ##[1:CAL_BND] !st_ff.calib;
	endproperty
	a_calib: assert property (p_calib)
		else $error("calibration bit never cleared");
endmodule : ralc_core

// ---- testbench/ralc_adc_model.sv ----
/*
 * Behavioural ADC filter path: one sample every fourth cycle while run
 * is high. Assumes the bench changes run, chan and mag after an edge.
 */
`timescale 1ns/100ps
module ralc_adc_model
	import ralc_pkg::*;
(
	input  wire logic             clk,      // System clock.
	input  wire logic             sys_rst,  // Asynchronous reset.
	input  wire logic             run,      // Keep sending samples.
	input  wire logic [1:0]       chan,     // Channel to send on.
	input  wire logic [SMP_W-1:0] mag,      // Sample value to send.
	output logic                  smpValid, // Sample strobe.
	output logic [1:0]            smpChan,  // Sample channel.
	output logic [SMP_W-1:0]      smpData,  // Sample value.
	output logic [15:0]           sentCnt   // Samples sent so far.
);
	logic [1:0] gap_ff;

	// Between strobes the data bus is inverted so a stale value never
	// passes for a fresh sample.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_ff   <= 2'h0;
			smpValid <= 1'b0;
			smpChan  <= 2'h0;
			smpData  <= 24'h00_0000;
			sentCnt  <= 16'h0000;
		end else if (run && gap_ff == 2'h3) begin
			gap_ff   <= 2'h0;
			smpValid <= 1'b1;
			smpChan  <= chan;
			smpData  <= mag;
			sentCnt  <= sentCnt + 16'h0001;
		end else begin
			gap_ff   <= gap_ff + 2'h1;
			smpValid <= 1'b0;
			smpChan  <= ~smpChan;
			smpData  <= ~smpData;
		end
	end
endmodule : ralc_adc_model

// ---- testbench/test_record_auto_level_control.sv ----
/*
 * Self-checking bench for the level control loop, driven over AHB-Lite.
 * Assumes ralc_pkg, the design and the ADC model are compiled first.
 */
`timescale 1ns/100ps
module test_record_auto_level_control;
	import ralc_pkg::*;
	logic                 clk     = 1'b0;
	logic                 sys_rst = 1'b1;
	logic                 hsel    = 1'b0;
	logic [31:0]          haddr   = 32'h0000_0000;
	logic [1:0]           htrans  = 2'h0;
	logic                 hwrite  = 1'b0;
	logic [31:0]          hwdata  = 32'h0000_0000;
	logic                 run     = 1'b0;
	logic [1:0]           chan    = 2'h0;
	logic [SMP_W-1:0]     mag     = 24'h00_0000;
	logic [31:0]          rd;
	logic                 ce      = 1'b1;
	int                   nWait;
	int                   nErrors = 0;
	int                   nTests  = 0;
	wire logic            hreadyout, hresp, smpValid, calibRun;
	wire logic [31:0]     hrdata;
	wire logic [1:0]      smpChan;
	wire logic [SMP_W-1:0] smpData;
	wire logic [NCH*DIG_W-1:0] digGain;
	wire logic [NCH*ANA_W-1:0] anaGain;
	wire logic [15:0]     sentCnt;

	always #12.5 clk = ~clk;

	ralc_core dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .smpValid(smpValid),
		.smpChan(smpChan), .smpData(smpData), .digGain(digGain),
		.anaGain(anaGain), .calibRun(calibRun));
	ralc_adc_model adc (.clk(clk), .sys_rst(sys_rst), .run(run),
		.chan(chan), .mag(mag), .smpValid(smpValid), .smpChan(smpChan),
		.smpData(smpData), .sentCnt(sentCnt));

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			nErrors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Waits for hready at a rising edge; only the watchdog ends a hang.
	task automatic waitRdy(output int n);
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			@(posedge clk);
		end
	endtask : waitRdy

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {24'h00_0000, a};
		waitRdy(nWait);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitRdy(nWait);
		rd = hrdata;
	endtask : bus

	task automatic rdChk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
		chk("read wait", 32'h0000_0001, 32'(nWait));
	endtask : rdChk

	// Sample to gain output takes three edges, so six cycles settle it.
	task automatic send(input logic [1:0] c, input logic [SMP_W-1:0] m,
		input int n);
		logic [15:0] t;
		t = sentCnt + 16'(n);
		run  <= 1'b1;
		chan <= c;
		mag  <= m;
		while (sentCnt !== t)
			@(posedge clk);
		run <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : send

	function automatic logic [31:0] dg(input int c);
		return 32'(digGain[DIG_W*c +: DIG_W]);
	endfunction : dg

	function automatic logic [31:0] ag(input int c);
		return 32'(anaGain[ANA_W*c +: ANA_W]);
	endfunction : ag

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrapUp

	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		wrapUp();
	end

	initial begin
		logic [7:0]  ad [6];
		logic [31:0] ex [6];
		int          d1;
		ad = '{OFF_CTRL_A, OFF_CTRL_B, OFF_CTRL_C, OFF_THR, OFF_LIM, 8'h40};
		ex[0] = 32'h0000_0000;
		ex[1] = (32'(RST_REL) << CB_REL) | (32'(RST_ATK) << CB_ATK);
		ex[2] = (32'(RST_ACS) << CC_ACS) | (32'(RST_HOLD) << CC_HOLD);
		ex[3] = (32'(RST_NOISE) << TH_NOISE) | (32'(RST_THMAX) << TH_MAX)
			| (32'(RST_THMIN) << TH_MIN);
		ex[4] = (32'(RST_AMAX) << LM_AMAX) | (32'(RST_AMIN) << LM_AMIN)
			| (32'(RST_DMAX) << LM_DMAX) | (32'(RST_DMIN) << LM_DMIN);
		ex[5] = 32'h0000_0000;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("digGain", 32'({NCH{RST_DIG}}), 32'(digGain));
		chk("anaGain", 32'({NCH{RST_AMP}}), 32'(anaGain));
		chk("calibRun", 32'h0000_0000, 32'(calibRun));
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		for (int i = 0; i < 6; i++)
			rdChk("register", ad[i], ex[i]);
		chk("hresp", 32'h0000_0000, 32'(hresp));
		$display("test reset done");
		bus(1'b1, OFF_CHG, 32'h0000_0348);
		send(2'h0, 24'h01_0000, 2);
		chk("direct dig", 32'h0000_0048, dg(0));
		chk("direct amp", 32'h0000_0003, ag(0));
		$display("test direct done");
		bus(1'b1, OFF_LIM, 32'h0F02_5030);
		bus(1'b1, OFF_CTRL_B, 32'h0000_0010);
		bus(1'b1, OFF_CTRL_C, 32'h0000_0204);
		bus(1'b1, OFF_CTRL_A, 32'h0000_0001);
		send(2'h0, 24'h10_0000, 40);
		chk("loud dig", 32'h0000_0030, dg(0));
		chk("loud amp", 32'h0000_0003, ag(0));
		rdChk("gain reg", OFF_CHG, 32'h0000_0348);
		chk("idle chan", 32'(RST_DIG), dg(1));
		send(2'h0, 24'h00_0100, 2);
		chk("hold dig", 32'h0000_0030, dg(0));
		bus(1'b0, OFF_STAT, 32'h0000_0000);
		chk("phase", 32'(PH_HOLD), 32'(rd[ST_PH +: 2]));
		send(2'h0, 24'h01_0000, 10);
		chk("window dig", 32'h0000_0030, dg(0));
		send(2'h0, 24'h00_0004, 10);
		chk("noise dig", 32'h0000_0030, dg(0));
		send(2'h0, 24'h00_0100, 10);
		chk("decay dig", 32'h0000_0035, dg(0));
		send(2'h0, 24'h00_0100, 60);
		chk("quiet dig", 32'h0000_0050, dg(0));
		$display("test digital done");
		// Offset calibration must finish before the hybrid loop runs.
		bus(1'b1, OFF_CTRL_A, 32'h0000_0040);
		repeat (2) @(posedge clk);
		chk("calibRun", 32'h0000_0001, 32'(calibRun));
		while (calibRun !== 1'b0)
			@(posedge clk);
		rdChk("calib bit", OFF_CTRL_A, 32'h0000_0000);
		bus(1'b1, OFF_CTRL_A, 32'h0000_0011);
		send(2'h0, 24'h10_0000, 60);
		chk("hyb amp", 32'h0000_0002, ag(0));
		chk("hyb dig", 32'h0000_0030, dg(0));
		rdChk("gain reg", OFF_CHG, 32'h0000_0348);
		$display("test hybrid done");
		bus(1'b1, OFF_CTRL_B, 32'h0000_00F3);
		// A disable between runs reseeds the loop from the channel gains.
		bus(1'b1, OFF_CTRL_A, 32'h0000_0020);
		bus(1'b1, OFF_CTRL_A, 32'h0000_0021);
		send(2'h0, 24'h40_0000, 8);
		d1 = 32'h0000_0048 - dg(0);
		bus(1'b1, OFF_CTRL_A, 32'h0000_0000);
		send(2'h0, 24'h01_0000, 1);
		bus(1'b1, OFF_CTRL_A, 32'h0000_0001);
		send(2'h0, 24'h40_0000, 8);
		chk("clip faster", 32'h0000_0001,
			32'(d1 > 32'h0000_0048 - dg(0)));
		ce <= 1'b0;
		send(2'h0, 24'h40_0000, 4);
		chk("frozen dig", 32'h0000_0046, dg(0));
		ce <= 1'b1;
		$display("test anticlip done");
		wrapUp();
	end
endmodule : test_record_auto_level_control
